// ===== flash_write_sequencer.sv
// Flash write sequencer: control registers, protection and operation flow.
`timescale 1ns/1ps
module flash_write_sequencer
	import flash_seq_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire reg_write_t reg_wr_i,
	input wire logic fetch_from_flash_i,
	input wire logic [3:0] prog_sector_i,
	input wire logic [15:0] nv_write_protect_low_i,
	input wire logic [15:0] nv_write_protect_high_i,
	input wire logic [15:0] nv_access0_i,
	input wire logic [15:0] nv_disable_i,
	input wire logic [15:0] nv_reenable_i,
	input wire logic array_done_i,
	output logic [15:0] control0_high_o,
	output logic [15:0] control0_low_o,
	output logic [15:0] sector_select_low_o,
	output logic [15:0] sector_select_high_o,
	output logic [15:0] error_register_o,
	output logic busy_o,
	output logic reg_reject_o,
	output logic array_start_o,
	output logic array_suspend_o,
	output logic array_abort_o,
	output array_cmd_t array_cmd_o
);

	seq_state_t state_q;
	array_op_t op_q;
	logic [15:0] addr_low_q;
	logic [15:0] addr_high_q;
	logic [15:0] data0_low_q;
	logic [15:0] data0_high_q;
	logic [15:0] data1_low_q;
	logic [15:0] data1_high_q;
	logic [NUM_SECTORS-1:0] unprot_wp_q;
	logic unprot_acc_q;

	logic [15:0] wd;
	logic wr_ok;
	logic ctrl_wr;
	logic start_wr;
	logic data_wr;
	logic acc_active;
	logic [NUM_SECTORS-1:0] nv_wp;
	logic [NUM_SECTORS-1:0] prog_mask;
	logic [NUM_SECTORS-1:0] erase_mask;
	logic blocked;
	logic nv_addr_ok;
	logic [15:0] nv_pair;
	logic [15:0] pds_ok;
	logic [15:0] pen_ok;
	array_op_t new_op;
	array_cmd_t cmd;
	logic act_launch;
	logic act_resume;
	logic act_pis;
	logic act_abort;
	logic act_suspend;
	logic act_done;
	logic act_erase_gone;
	logic err_op;
	logic err_prot;

	// Exactly one select bit, with the mode bit set unless protecting.
	function automatic logic select_ok(input logic [15:0] d);
		logic [3:0] ops;
		ops = {d[13], d[12], d[11], d[8]};
		select_ok = (ops != 4'h0) && ((ops & (ops - 4'h1)) == 4'h0) &&
			(((d & SUSPEND_MODE_CONTROL_MASK) != 16'h0) == ((d & SPR_MASK) == 16'h0));
	endfunction

	function automatic array_op_t op_of(input logic [15:0] d);
		if ((d & WPG_MASK) != 16'h0) begin
			op_of = OP_WORD;
		end else if ((d & DOUBLE_WORD_PROGRAM_SELECT_MASK) != 16'h0) begin
			op_of = OP_DWORD;
		end else if ((d & SER_MASK) != 16'h0) begin
			op_of = OP_ERASE;
		end else begin
			op_of = OP_PROTECT;
		end
	endfunction

	// Write decode; direct-addressed and protected writes are refused.
	assign wd = reg_wr_i.data;
	assign acc_active = ((nv_access0_i & ACCESS_PROTECT_MASK) == 16'h0) &&
		!unprot_acc_q;
	assign wr_ok = reg_wr_i.valid && reg_wr_i.indirect &&
		!(acc_active && !fetch_from_flash_i);
	assign ctrl_wr = wr_ok && (reg_wr_i.sel == SEL_CONTROL0_HIGH);
	assign start_wr = ctrl_wr && ((wd & START_MASK) != 16'h0);
	assign data_wr = wr_ok && (state_q == ST_IDLE || state_q == ST_SUSPEND_BIT);
	assign new_op = op_of(wd);

	// Effective protection: NV bit at zero and no temporary lift.
	assign nv_wp = {nv_write_protect_high_i[BANK1_SECTORS-1:0],
		nv_write_protect_low_i[BANK0_SECTORS-1:0]};
	assign prog_mask = NUM_SECTORS'(12'h001 << prog_sector_i);
	assign erase_mask = {sector_select_high_o[BANK1_SECTORS-1:0],
		sector_select_low_o[BANK0_SECTORS-1:0]};
	always_comb begin
		if (new_op == OP_ERASE) begin
			blocked = |(erase_mask & ~nv_wp & ~unprot_wp_q);
		end else if (new_op == OP_PROTECT) begin
			blocked = 1'b0;
		end else begin
			blocked = |(prog_mask & ~nv_wp & ~unprot_wp_q);
		end
	end

	// Set-protection target must be one of the NV protection pairs.
	assign nv_pair = addr_low_q & NV_PAIR_MASK;
	assign nv_addr_ok = (addr_high_q == NV_SEGMENT) &&
		(nv_pair == NV_WRITE_PROTECT_ADDR || nv_pair == NV_ACCESS0_ADDR ||
		nv_pair == NV_ACCESS1_ADDR);

	// Disable bit x may drop only after re-enable x-1; the first only
	// once access and debug protection are both set, which caps the
	// permanent toggles at the width of the pair.
	assign pds_ok = ~{nv_reenable_i[14:0],
		!((nv_access0_i & (ACCESS_PROTECT_MASK | DEBUG_PROTECT_MASK)) ==
		16'h0)};
	assign pen_ok = ~nv_disable_i;

	// Command toward the array, built from the loaded registers.
	always_comb begin
		cmd.op = new_op;
		cmd.addr = {addr_high_q, addr_low_q};
		cmd.data = {data1_high_q, data1_low_q, data0_high_q, data0_low_q};
		cmd.sectors = {sector_select_high_o, sector_select_low_o};
		if (new_op == OP_DWORD) begin
			cmd.addr = {addr_high_q, addr_low_q & ~ADDR2_MASK};
		end
		if (new_op == OP_WORD || new_op == OP_PROTECT) begin
			cmd.data = {32'h0000_0000, data0_high_q, data0_low_q};
		end
		if (new_op == OP_PROTECT && nv_pair == NV_ACCESS1_ADDR) begin
			cmd.data = {32'h0000_0000, data0_high_q | ~pen_ok,
				data0_low_q | ~pds_ok};
		end
	end

	// Sequencing decisions for this cycle.
	always_comb begin
		act_launch = 1'b0;
		act_resume = 1'b0;
		act_pis = 1'b0;
		act_abort = 1'b0;
		act_suspend = 1'b0;
		act_done = 1'b0;
		act_erase_gone = 1'b0;
		err_op = 1'b0;
		err_prot = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (start_wr) begin
					if (!select_ok(wd) || (wd & SUSPEND_BIT_MASK) != 16'h0) begin
						err_op = 1'b1;
					end else if (new_op == OP_PROTECT && !nv_addr_ok) begin
						err_op = 1'b1;
					end else if (blocked) begin
						err_prot = 1'b1;
					end else begin
						act_launch = 1'b1;
					end
				end
			end
			ST_RUN: begin
				if (array_done_i) begin
					act_done = 1'b1;
				end else if (ctrl_wr && (wd & SUSPEND_BIT_MASK) != 16'h0 &&
						op_q != OP_PROTECT) begin
					act_suspend = 1'b1;
				end
			end
			ST_SUSPEND_BIT: begin
				if (start_wr) begin
					if ((wd & SUSPEND_BIT_MASK) != 16'h0) begin
						err_op = 1'b1;
					end else if (select_ok(wd) && new_op == op_q) begin
						act_resume = 1'b1;
					end else if (select_ok(wd) && op_q == OP_ERASE &&
							(new_op == OP_WORD || new_op == OP_DWORD)) begin
						if (blocked) begin
							err_prot = 1'b1;
						end else begin
							act_pis = 1'b1;
						end
					end else begin
						act_abort = 1'b1;
					end
				end else if (array_done_i) begin
					act_erase_gone = 1'b1;
				end
			end
			ST_PGM_IN_SUSPEND_BIT: begin
				if (array_done_i) begin
					act_done = 1'b1;
				end
			end
			default: begin
				act_abort = 1'b1;
			end
		endcase
	end

	// Operation state; program in erase suspend returns to suspended.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			op_q <= OP_WORD;
		end else if (act_launch) begin
			state_q <= ST_RUN;
			op_q <= new_op;
		end else if (act_resume) begin
			state_q <= ST_RUN;
		end else if (act_pis) begin
			state_q <= ST_PGM_IN_SUSPEND_BIT;
		end else if (act_suspend) begin
			state_q <= ST_SUSPEND_BIT;
		end else if (act_abort) begin
			state_q <= ST_IDLE;
		end else if (act_done) begin
			state_q <= (state_q == ST_PGM_IN_SUSPEND_BIT) ? ST_SUSPEND_BIT : ST_IDLE;
		end
	end

	// Control register zero; while running only a suspend gets through.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			control0_high_o <= CTRL_RESET;
		end else if (act_launch || act_resume) begin
			control0_high_o <= wd;
		end else if (act_pis) begin
			control0_high_o <= wd & ~(SER_MASK | SUSPEND_BIT_MASK);
		end else if (act_suspend || err_op || err_prot) begin
			control0_high_o <= wd & ~START_MASK;
		end else if (act_abort) begin
			control0_high_o <= CTRL_RESET;
		end else if (act_done) begin
			control0_high_o <= control0_high_o & ~(START_MASK | WPG_MASK |
				DOUBLE_WORD_PROGRAM_SELECT_MASK | SER_MASK | SPR_MASK);
		end else if (ctrl_wr && data_wr) begin
			control0_high_o <= wd;
		end
	end

	// Plain storage registers, frozen while the array is busy.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			control0_low_o <= CTRL_RESET;
			addr_low_q <= 16'h0000;
			addr_high_q <= 16'h0000;
			data0_low_q <= 16'h0000;
			data0_high_q <= 16'h0000;
			data1_low_q <= 16'h0000;
			data1_high_q <= 16'h0000;
		end else if (data_wr) begin
			case (reg_wr_i.sel)
				SEL_CONTROL0_LOW: control0_low_o <= wd;
				SEL_ADDRESS_LOW: addr_low_q <= wd;
				SEL_ADDRESS_HIGH: addr_high_q <= wd;
				SEL_DATA0_LOW: data0_low_q <= wd;
				SEL_DATA0_HIGH: data0_high_q <= wd;
				SEL_DATA1_LOW: data1_low_q <= wd;
				SEL_DATA1_HIGH: data1_high_q <= wd;
				default: begin
				end
			endcase
		end
	end

	// Sector mask; cleared when the erase finishes or is aborted.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sector_select_low_o <= SECTOR_RESET;
			sector_select_high_o <= SECTOR_RESET;
		end else if (act_erase_gone || act_abort ||
				(act_done && op_q == OP_ERASE && state_q == ST_RUN)) begin
			sector_select_low_o <= SECTOR_RESET;
			sector_select_high_o <= SECTOR_RESET;
		end else if (data_wr && reg_wr_i.sel == SEL_SECTOR_LOW) begin
			sector_select_low_o <= wd;
		end else if (data_wr && reg_wr_i.sel == SEL_SECTOR_HIGH) begin
			sector_select_high_o <= wd;
		end
	end

	// Error flags; a new error wins over a software clear.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			error_register_o <= 16'h0000;
		end else begin
			error_register_o <= ((wr_ok && reg_wr_i.sel == SEL_ERROR) ?
				(error_register_o & wd) : error_register_o) |
				(act_abort ? ERR_RESUME_MASK : 16'h0000) |
				(err_prot ? ERR_PROTECT_MASK : 16'h0000) |
				(err_op ? ERR_OPERATION_MASK : 16'h0000);
		end
	end

	// Volatile protection copies; NV content is never touched here,
	// so a temporary lift cannot be seen by reading NV back.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			unprot_wp_q <= '0;
			unprot_acc_q <= 1'b0;
		end else if (act_launch && new_op == OP_PROTECT) begin
			if (nv_pair == NV_WRITE_PROTECT_ADDR) begin
				unprot_wp_q <= {data0_high_q[BANK1_SECTORS-1:0],
					data0_low_q[BANK0_SECTORS-1:0]};
			end else if (nv_pair == NV_ACCESS0_ADDR) begin
				unprot_acc_q <= (data0_low_q & ACCESS_PROTECT_MASK) !=
					16'h0;
			end
		end
	end

	// Array handshake: start and abort pulse, suspend is a level.
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			array_start_o <= 1'b0;
			array_abort_o <= 1'b0;
			array_suspend_o <= 1'b0;
			array_cmd_o <= '0;
			busy_o <= 1'b0;
			reg_reject_o <= 1'b0;
		end else begin
			array_start_o <= act_launch || act_pis;
			array_abort_o <= act_abort;
			if (act_suspend) begin
				array_suspend_o <= 1'b1;
			end else if (act_resume || act_abort) begin
				array_suspend_o <= 1'b0;
			end
			if (act_launch || act_pis) begin
				array_cmd_o <= cmd;
			end
			busy_o <= (state_q == ST_RUN || state_q == ST_PGM_IN_SUSPEND_BIT ||
				act_launch || act_resume || act_pis) &&
				!(act_done || act_suspend);
			reg_reject_o <= reg_wr_i.valid && (!wr_ok ||
				(!data_wr && !act_suspend) || err_op || err_prot);
		end
	end

endmodule

// ===== flash_seq_pkg.sv
// Constants, field masks and carrier types of the flash write sequencer.
// How it works
// - Zero write-protect bit blocks program and erase.
// - Set-protection writing 1 lifts protection temporarily.
// - Reset or writing 0 restores lifted protection.
// - Only the volatile copy changes; NV stays 0.
// - Code fetched from flash may update protected flash.
// - Control register writes are 16 bits wide.
// - Word program needs select plus mode bit; 32 bits.
// - Double word ignores address bit two; 64 bits.
// - Sector erase: select, mode bit, sector mask.
// - Select, load address and data, then start.
// - Start bit in control register zero launches.
// - Clearing select before start cancels the operation.
// - Suspend bit suspends program or erase.
// - Completed suspended erase reads sector select zero.
// - Resume without original select aborts, flags error.
// - Erase resumes with erase select then start.
// - Program in erase suspend is not suspendable.
// - Set-protection: own select, mode bit clear.
// - Permanent protection toggles limited to sixteen.
// - Bank zero has ten sector protect bits.
package flash_seq_pkg;

	// Control register zero, high half; address bit two mask; reset values.
	localparam logic [15:0] START_MASK = 16'h8000;
	localparam logic [15:0] SUSPEND_BIT_MASK = 16'h4000;
	localparam logic [15:0] WPG_MASK = 16'h2000;
	localparam logic [15:0] DOUBLE_WORD_PROGRAM_SELECT_MASK = 16'h1000;
	localparam logic [15:0] SER_MASK = 16'h0800;
	localparam logic [15:0] SPR_MASK = 16'h0100;
	localparam logic [15:0] SUSPEND_MODE_CONTROL_MASK = 16'h0080;
	localparam logic [15:0] ADDR2_MASK = 16'h0004;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] SECTOR_RESET = 16'h0000;

	// Error register fields.
	localparam logic [15:0] ERR_RESUME_MASK = 16'h0001;
	localparam logic [15:0] ERR_PROTECT_MASK = 16'h0002;
	localparam logic [15:0] ERR_OPERATION_MASK = 16'h0004;

	// Non-volatile protection register map, word-pair aligned.
	localparam logic [15:0] NV_SEGMENT = 16'h000e;
	localparam logic [15:0] NV_WRITE_PROTECT_ADDR = 16'hdfb4;
	localparam logic [15:0] NV_ACCESS0_ADDR = 16'hdfb8;
	localparam logic [15:0] NV_ACCESS1_ADDR = 16'hdfbc;
	localparam logic [15:0] NV_PAIR_MASK = 16'hfffc;
	localparam logic [15:0] ACCESS_PROTECT_MASK = 16'h0001;
	localparam logic [15:0] DEBUG_PROTECT_MASK = 16'h0002;

	// Sector layout.
	localparam int BANK0_SECTORS = 10;
	localparam int BANK1_SECTORS = 2;
	localparam int NUM_SECTORS = BANK0_SECTORS + BANK1_SECTORS;

	typedef enum logic [3:0] {
		SEL_CONTROL0_LOW = 4'h0,
		SEL_CONTROL0_HIGH = 4'h1,
		SEL_SECTOR_LOW = 4'h2,
		SEL_SECTOR_HIGH = 4'h3,
		SEL_ADDRESS_LOW = 4'h4,
		SEL_ADDRESS_HIGH = 4'h5,
		SEL_DATA0_LOW = 4'h6,
		SEL_DATA0_HIGH = 4'h7,
		SEL_DATA1_LOW = 4'h8,
		SEL_DATA1_HIGH = 4'h9,
		SEL_ERROR = 4'ha
	} reg_sel_t;

	typedef enum logic [1:0] {
		OP_WORD = 2'h0,
		OP_DWORD = 2'h1,
		OP_ERASE = 2'h2,
		OP_PROTECT = 2'h3
	} array_op_t;

	// Gray coded along idle, run, suspended, program in suspend.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_SUSPEND_BIT = 2'b11,
		ST_PGM_IN_SUSPEND_BIT = 2'b10
	} seq_state_t;

	typedef struct packed {
		logic valid;
		logic indirect;
		reg_sel_t sel;
		logic [15:0] data;
	} reg_write_t;

	typedef struct packed {
		array_op_t op;
		logic [31:0] addr;
		logic [63:0] data;
		logic [31:0] sectors;
	} array_cmd_t;

endpackage

// ===== flash_seq_asserts.sv
// Concurrent checks on the ports of the flash write sequencer.
`timescale 1ns/1ps
module flash_seq_asserts
	import flash_seq_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire reg_write_t reg_wr_i,
	input wire logic fetch_from_flash_i,
	input wire logic [3:0] prog_sector_i,
	input wire logic [15:0] nv_write_protect_low_i,
	input wire logic [15:0] nv_write_protect_high_i,
	input wire logic [15:0] nv_access0_i,
	input wire logic [15:0] nv_disable_i,
	input wire logic [15:0] nv_reenable_i,
	input wire logic array_done_i,
	input wire logic [15:0] control0_high_o,
	input wire logic [15:0] control0_low_o,
	input wire logic [15:0] sector_select_low_o,
	input wire logic [15:0] sector_select_high_o,
	input wire logic [15:0] error_register_o,
	input wire logic busy_o,
	input wire logic reg_reject_o,
	input wire logic array_start_o,
	input wire logic array_suspend_o,
	input wire logic array_abort_o,
	input wire array_cmd_t array_cmd_o
);
	// One clock domain, so clock and reset are stated once.
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	logic c0h_wr;
	// Only writes that access protection cannot refuse qualify here.
	assign c0h_wr = reg_wr_i.valid && reg_wr_i.indirect &&
		(fetch_from_flash_i || nv_access0_i[0]) &&
		reg_wr_i.sel == SEL_CONTROL0_HIGH;
	property p_direct;
		reg_wr_i.valid && !reg_wr_i.indirect |=> reg_reject_o;
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct write not refused");
	property p_start;
		array_start_o |-> busy_o && control0_high_o[15];
	endproperty
	a_start: assert property (p_start)
		else $error("start without busy and start bit");
	property p_done;
		busy_o && array_done_i |=> !busy_o && !control0_high_o[15];
	endproperty
	a_done: assert property (p_done)
		else $error("start bit or busy kept after completion");
	property p_dword;
		array_start_o && array_cmd_o.op == OP_DWORD |-> !array_cmd_o.addr[2];
	endproperty
	a_dword: assert property (p_dword)
		else $error("double word address not aligned");
	property p_pis;
		busy_o && array_suspend_o |-> !control0_high_o[14] &&
			!control0_high_o[11];
	endproperty
	a_pis: assert property (p_pis)
		else $error("erase or suspend bit high in suspended program");
	property p_erased;
		array_suspend_o && !busy_o && array_done_i &&
			!(reg_wr_i.valid && reg_wr_i.sel == SEL_CONTROL0_HIGH &&
			reg_wr_i.data[15]) |=>
			sector_select_low_o == 16'h0000 &&
			sector_select_high_o == 16'h0000;
	endproperty
	a_erased: assert property (p_erased)
		else $error("sector mask not zero after suspended erase");
	property p_abort;
		array_abort_o |-> ##[0:1] error_register_o[0];
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort without resume error");
	property p_suspend_bit;
		c0h_wr && reg_wr_i.data[14] && busy_o && !array_suspend_o &&
			!array_done_i && array_cmd_o.op != OP_PROTECT
			|=> array_suspend_o && !busy_o;
	endproperty
	a_suspend_bit: assert property (p_suspend_bit)
		else $error("suspend request not obeyed");
	property p_nosusp_start;
		c0h_wr && reg_wr_i.data[15] && reg_wr_i.data[14] && !busy_o
			|=> !array_start_o;
	endproperty
	a_nosusp_start: assert property (p_nosusp_start)
		else $error("start accepted with suspend bit set");
	c_erase: cover property (array_start_o && array_cmd_o.op == OP_ERASE);
	c_pis: cover property (busy_o && array_suspend_o);
	c_abort: cover property (array_abort_o);
endmodule
bind flash_write_sequencer flash_seq_asserts u_chk (.clk_sys_i, .rst_i,
	.reg_wr_i, .fetch_from_flash_i, .prog_sector_i, .nv_write_protect_low_i,
	.nv_write_protect_high_i, .nv_access0_i, .nv_disable_i, .nv_reenable_i,
	.array_done_i, .control0_high_o, .control0_low_o, .sector_select_low_o,
	.sector_select_high_o, .error_register_o, .busy_o, .reg_reject_o,
	.array_start_o, .array_suspend_o, .array_abort_o, .array_cmd_o);

// ===== testbench.sv
// Self-checking bench for the flash write sequencer.
`timescale 1ns/1ps
module testbench;
	import flash_seq_pkg::*;
	logic clk_sys_i, rst_i, fetch, done_p;
	reg_write_t wr_s;
	logic [3:0] psec;
	logic [15:0] wp_lo, acc0, c0h, c0l, ssl, ssh, err;
	logic busy, rej, st, sp, ab;
	array_cmd_t cmd;
	logic [31:0] rnd;
	int error_cnt = 0;
	int num_checks = 0;
	int seed = 13;
	flash_write_sequencer DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.reg_wr_i(wr_s), .fetch_from_flash_i(fetch), .prog_sector_i(psec),
		.nv_write_protect_low_i(wp_lo), .nv_write_protect_high_i(16'hffff),
		.nv_access0_i(acc0), .nv_disable_i(16'hffff),
		.nv_reenable_i(16'hffff), .array_done_i(done_p),
		.control0_high_o(c0h), .control0_low_o(c0l),
		.sector_select_low_o(ssl), .sector_select_high_o(ssh),
		.error_register_o(err), .busy_o(busy), .reg_reject_o(rej),
		.array_start_o(st), .array_suspend_o(sp), .array_abort_o(ab),
		.array_cmd_o(cmd));
	// Free-running 250 MHz clock.
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	// Every comparison is counted; a mismatch is reported at once.
	task automatic chk(input string nm, input logic [129:0] s, e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One-cycle write strobe, launched and dropped on falling edges.
	task automatic wr(input logic ind, input reg_sel_t sl, input logic [15:0] d);
		@(negedge clk_sys_i);
		wr_s = '{1'b1, ind, sl, d};
		@(negedge clk_sys_i);
		wr_s.valid = 1'b0;
	endtask
	task automatic c0(input logic [15:0] d);
		wr(1'b1, SEL_CONTROL0_HIGH, d);
	endtask
	// Address and both data pairs, low halves first.
	task automatic ld(input logic [31:0] a, input logic [63:0] d);
		wr(1'b1, SEL_ADDRESS_LOW, a[15:0]);
		wr(1'b1, SEL_ADDRESS_HIGH, a[31:16]);
		wr(1'b1, SEL_DATA0_LOW, d[15:0]);
		wr(1'b1, SEL_DATA0_HIGH, d[31:16]);
		wr(1'b1, SEL_DATA1_LOW, d[47:32]);
		wr(1'b1, SEL_DATA1_HIGH, d[63:48]);
	endtask
	// Select, load, then start: the three-step sequence.
	task automatic run(input logic [15:0] s, input logic [31:0] a,
		input logic [63:0] d);
		c0(s);
		ld(a, d);
		c0(s | 16'h8000);
	endtask
	task automatic done();
		@(negedge clk_sys_i);
		done_p = 1'b1;
		@(negedge clk_sys_i);
		done_p = 1'b0;
	endtask
	task automatic final_report();
		if (error_cnt == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Main sequence; every expectation is worked out from the rules.
	initial begin
		rst_i = 1'b1;
		wr_s = '0;
		fetch = 1'b0;
		done_p = 1'b0;
		psec = 4'h1;
		wp_lo = 16'hffff;
		acc0 = 16'hffff;
		repeat (4) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rst_i = 1'b0;
		chk("ctrl", c0h, 16'h0000);
		chk("err", err, 16'h0000);
		rnd = $random(seed);
		run(16'h2080, 32'h0002_5554, {32'h0, rnd});
		chk("start", st, 1'b1);
		chk("op", cmd.op, OP_WORD);
		chk("addr", cmd.addr, 32'h0002_5554);
		chk("data", cmd.data[31:0], rnd);
		chk("run", c0h, 16'ha080);
		done();
		chk("idle", c0h, 16'h0080);
		run(16'h1080, 32'h0003_555c, 64'haa55aa55_55aa55aa);
		chk("addr", cmd.addr, 32'h0003_5558);
		chk("data", cmd.data, 64'haa55aa55_55aa55aa);
		done();
		wr(1'b0, SEL_CONTROL0_LOW, 16'h1234);
		chk("reject", rej, 1'b1);
		chk("low", c0l, 16'h0000);
		wr(1'b1, SEL_CONTROL0_LOW, 16'h1234);
		chk("low", c0l, 16'h1234);
		acc0 = 16'hfffe;
		wr(1'b1, SEL_CONTROL0_LOW, 16'h5a5a);
		chk("reject", rej, 1'b1);
		fetch = 1'b1;
		wr(1'b1, SEL_CONTROL0_LOW, 16'h5a5a);
		chk("low", c0l, 16'h5a5a);
		c0(16'h2080);
		c0(16'h0080);
		c0(16'h8080);
		chk("start", st, 1'b0);
		c0(16'he080);
		chk("start", st, 1'b0);
		chk("ctrl", c0h, 16'h6080);
		wr(1'b1, SEL_ERROR, 16'h0000);
		wp_lo = 16'h03fe;
		psec = 4'h0;
		run(16'h2080, 32'h0, 64'h0);
		chk("start", st, 1'b0);
		chk("err", err[1], 1'b1);
		chk("ctrl", c0h, 16'h2080);
		wr(1'b1, SEL_ERROR, 16'h0000);
		run(16'h0100, 32'h000e_dfb4, 64'hffff);
		chk("op", cmd.op, OP_PROTECT);
		done();
		run(16'h2080, 32'h0, 64'h0);
		chk("start", st, 1'b1);
		done();
		run(16'h0100, 32'h000e_dfb4, 64'hfffe);
		done();
		run(16'h2080, 32'h0, 64'h0);
		chk("start", st, 1'b0);
		// Debug protection is still erased, so no disable bit may drop.
		run(16'h0100, 32'h000e_dfbc, 64'hfffe_fffe);
		chk("pair", cmd.data[31:0], 32'hffff_ffff);
		done();
		// Lift access protection, then write from a non-flash fetch.
		run(16'h0100, 32'h000e_dfb8, 64'h0001);
		done();
		fetch = 1'b0;
		wr(1'b1, SEL_CONTROL0_LOW, 16'h0f0f);
		chk("low", c0l, 16'h0f0f);
		fetch = 1'b1;
		wr(1'b1, SEL_ERROR, 16'h0000);
		psec = 4'h1;
		c0(16'h0880);
		wr(1'b1, SEL_SECTOR_LOW, 16'h0002);
		c0(16'h8880);
		chk("op", cmd.op, OP_ERASE);
		chk("mask", cmd.sectors, 32'h2);
		c0(16'h4880);
		chk("suspend_bit", sp, 1'b1);
		chk("busy", busy, 1'b0);
		c0(16'h0080);
		run(16'h2080, 32'h0004_5554, 64'h5555aaaa);
		chk("start", st, 1'b1);
		chk("ctrl", c0h & 16'h4800, 16'h0000);
		c0(16'h6080);
		chk("busy", busy, 1'b1);
		done();
		c0(16'h0880);
		c0(16'h8880);
		chk("suspend_bit", sp, 1'b0);
		chk("busy", busy, 1'b1);
		c0(16'h4880);
		c0(16'h8100);
		chk("abort", ab, 1'b1);
		chk("err", err[0], 1'b1);
		chk("ctrl", c0h, 16'h0000);
		c0(16'h0880);
		// Sectors one and two are writable; sector zero is protected.
		wr(1'b1, SEL_SECTOR_LOW, 16'h0006);
		c0(16'h8880);
		chk("start", st, 1'b1);
		c0(16'h4880);
		chk("suspend_bit", sp, 1'b1);
		done();
		chk("mask", {ssh, ssl}, 32'h0);
		final_report();
	end
endmodule
